// [clock_source_select.sv]
/*
  internal clock source selection: models the low, mid and pll-derived
  high internal sources, chooses the system clock from the config
  field and software select, and decides clock pin use.
  assumes config inputs are stable straps and clock_in_pin is async.
*/
// The strobed register port and the register addresses were decided locally.
`timescale 1ns/1ps
`default_nettype none
module clock_source_select (
  input  wire logic       REF_CLK_I,
  input  wire logic       RST_I,
  input  wire logic [2:0] OSC_SELECT_CONFIG_I,
  input  wire logic       CLOCK_OUT_ENABLE_I,
  input  wire logic [1:0] ADDR_I,
  input  wire logic [7:0] WDATA_I,
  input  wire logic       WR_I,
  input  wire logic       RD_I,
  output logic      [7:0] RDATA_O,
  input  wire logic       CLOCK_IN_PIN_I,
  output logic            CLOCK_OUT_PIN_O,
  output logic            CLOCK_OUT_PIN_OE_O,
  output logic            CLOCK_IN_GPIO_O,
  output logic            CLOCK_OUT_GPIO_O,
  output logic            SYS_CLK_O,
  output logic      [1:0] SYS_SRC_O,
  output logic            SWITCH_BUSY_O,
  output logic            HIGH_FREQ_LOCK_O
);
  localparam int LOCK_CYC = clksel_pkg::LOCK_RISES;

  logic [7:0]  control_q;
  logic [5:0]  trim_q;
  logic [2:0]  cfg_q;
  logic        cfg_en_q;
  logic [1:0]  pin_sync_q;
  logic [clksel_pkg::ACC_W-1:0] mid_acc_q;
  logic [clksel_pkg::ACC_W-1:0] low_acc_q;
  logic        high_q;
  logic        mid_prev_q;
  logic [6:0]  lock_cnt_q;
  logic        lock_q;
  logic [7:0]  rdata_q;

  clk_switch_if csw ();

  glitchfree_mux u_mux (
    .clk_i (REF_CLK_I),
    .rst_i (RST_I),
    .sw    (csw.sw)
  );

  // strap captured by a clocked process at reset release
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      cfg_q    <= 3'h0;
      cfg_en_q <= 1'b0;
    end else if (!cfg_en_q) begin
      cfg_q    <= OSC_SELECT_CONFIG_I;
      cfg_en_q <= 1'b1;
    end
  end

  // registers
  wire wr_ctl  = WR_I && (ADDR_I == clksel_pkg::ADDR_CONTROL);
  wire wr_trim = WR_I && (ADDR_I == clksel_pkg::ADDR_TRIM);
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      control_q <= clksel_pkg::CONTROL_RESET;
      trim_q    <= clksel_pkg::TRIM_RESET;
    end else begin
      if (wr_ctl)  control_q <= WDATA_I;
      if (wr_trim) trim_q    <= WDATA_I[5:0];
    end
  end

  wire [1:0] clk_sel = control_q[clksel_pkg::CLK_SEL_LSB +: 2];
  wire [1:0] int_sel = control_q[clksel_pkg::INT_SEL_LSB +: 2];

  // low source: fixed increment, trim never applied
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) low_acc_q <= '0;
    else       low_acc_q <= low_acc_q + clksel_pkg::INC_LOW;
  end
  wire low_clk = low_acc_q[clksel_pkg::ACC_W-1];

  // mid source with signed trim
  // product taken at 32 bits: at 24 bits a large trim wraps its sign
  wire signed [31:0] trim_prod =
    32'(signed'(trim_q)) * 32'(signed'(clksel_pkg::INC_MID));
  wire signed [clksel_pkg::ACC_W-1:0] trim_delta =
    clksel_pkg::ACC_W'(trim_prod >>> clksel_pkg::TRIM_SHIFT);
  wire [clksel_pkg::ACC_W-1:0] mid_inc =
    clksel_pkg::INC_MID + clksel_pkg::ACC_W'(trim_delta);
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) mid_acc_q <= '0;
    else       mid_acc_q <= mid_acc_q + mid_inc;
  end
  wire mid_clk = mid_acc_q[clksel_pkg::ACC_W-1];

  // pll model: high source is a marker toggled on each mid rise
  // limitation: 16 MHz cannot be shown at 25 MHz, so high is a
  // frequency marker stepped by the mid edges, not a true waveform
  wire mid_rise = mid_clk & ~mid_prev_q;
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      mid_prev_q <= 1'b0;
      high_q     <= 1'b0;
    end else begin
      mid_prev_q <= mid_clk;
      if (mid_rise) high_q <= ~high_q;
    end
  end

  // lock after a fixed count of mid rises from mid activity
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      lock_cnt_q <= 7'h0;
      lock_q     <= 1'b0;
    end else if (!lock_q) begin
      if (mid_rise) lock_cnt_q <= 7'(lock_cnt_q + 7'h1);
      if (lock_cnt_q == 7'(LOCK_CYC)) lock_q <= 1'b1;
    end
  end
  wire high_clk = high_q & lock_q;

  // clock pin sync: two flops before use
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) pin_sync_q <= 2'h0;
    else       pin_sync_q <= {pin_sync_q[0], CLOCK_IN_PIN_I};
  end
  wire rc_clk = pin_sync_q[1];

  // source decision
  wire sw_int    = clk_sel[1];
  wire cfg_int   = (cfg_q == clksel_pkg::CFG_INT_MODE);
  wire cfg_rc    = (cfg_q == clksel_pkg::CFG_RC_MODE);
  wire use_int   = sw_int || cfg_int;
  wire use_rc    = !use_int && cfg_rc;
  wire [1:0] int_src =
    (int_sel == 2'h2) ? clksel_pkg::SRC_HIGH :
    (int_sel == 2'h1) ? clksel_pkg::SRC_MID : clksel_pkg::SRC_LOW;
  wire [1:0] sel =
    use_int ? int_src :
    use_rc  ? clksel_pkg::SRC_RC : clksel_pkg::SRC_LOW;

  assign csw.src_clk = {rc_clk, high_clk, mid_clk, low_clk};
  assign csw.sel     = sel;

  // pin usage
  wire int_mode = use_int;
  wire rc_mode  = use_rc;
  wire clkout_drive = (int_mode || rc_mode) && CLOCK_OUT_ENABLE_I;
  // the pin stays a clock input until the switch has left the rc source
  assign CLOCK_IN_GPIO_O    = int_mode &&
                              (csw.active != clksel_pkg::SRC_RC);
  assign CLOCK_OUT_GPIO_O   = (int_mode || rc_mode) &&
                              !CLOCK_OUT_ENABLE_I;
  assign CLOCK_OUT_PIN_OE_O = clkout_drive;
  assign CLOCK_OUT_PIN_O    = clkout_drive & csw.out_clk;

  assign SYS_CLK_O        = csw.out_clk;
  assign SYS_SRC_O        = csw.active;
  assign SWITCH_BUSY_O    = csw.busy;
  assign HIGH_FREQ_LOCK_O = lock_q;

  // read port: data in the cycle after the strobe only
  wire [7:0] status = {3'h0, lock_q, csw.busy, use_int, csw.active};
  wire [7:0] rsel =
    (ADDR_I == clksel_pkg::ADDR_CONTROL) ? control_q :
    (ADDR_I == clksel_pkg::ADDR_TRIM)    ? {2'h0, trim_q} :
    (ADDR_I == clksel_pkg::ADDR_STATUS)  ? status : 8'h00;
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I)     rdata_q <= 8'h00;
    else if (RD_I) rdata_q <= rsel;
    else           rdata_q <= 8'h00;
  end
  assign RDATA_O = rdata_q;
endmodule : clock_source_select
`default_nettype wire

// [clksel_pkg.sv]
/*
  constants for the internal clock source selection block: register
  offsets, field positions, reset values, mode encodings and timing.
  assumes a single 25 MHz reference clock and a plain register port.
*/
// Notes on behaviour
// - reset picks internal oscillator when config selects it
// - software clock-select field switches to internal oscillator
// - internal mode releases clock input pin to gpio
// - clock-out enable picks clock output or gpio
// - rc mode clocks from input pin, output pin follows clock-out enable
// - 16 MHz source derived from 500 kHz by pll; modelled as a marker toggled on each mid rise
// - 31 kHz low source, never trimmed
// - trim register adjusts mid and high sources
// - three internal sources from two oscillators plus pll
package clksel_pkg;
  // register indices (word address on the plain port)
  localparam logic [1:0] ADDR_CONTROL = 2'h0;
  localparam logic [1:0] ADDR_TRIM    = 2'h1;
  localparam logic [1:0] ADDR_STATUS  = 2'h2;
  // control register fields
  localparam int CLK_SEL_LSB = 0;
  localparam int INT_SEL_LSB = 2;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [5:0] TRIM_RESET    = 6'h00;
  // configuration oscillator-select encodings
  localparam logic [2:0] CFG_RC_MODE  = 3'h3;
  localparam logic [2:0] CFG_INT_MODE = 3'h4;
  // system clock select encodings
  typedef enum logic [1:0] {
    SEL_CONFIG = 2'b00,
    SEL_RSVD   = 2'b01,
    SEL_INT_A  = 2'b10,
    SEL_INT_B  = 2'b11
  } clk_sel_t;
  // system clock source choice, rc pin included
  typedef enum logic [1:0] {
    SRC_LOW  = 2'b00,
    SRC_MID  = 2'b01,
    SRC_HIGH = 2'b10,
    SRC_RC   = 2'b11
  } src_t;
  // frequencies in kHz
  localparam int REF_KHZ  = 25000;
  localparam int HIGH_KHZ = 16000;
  localparam int MID_KHZ  = 500;
  localparam int LOW_KHZ  = 31;
  localparam int PLL_MULT = HIGH_KHZ / MID_KHZ;
  // phase accumulator width for the modelled oscillators
  localparam int ACC_W    = 24;
  // nominal increments: f / fref * 2^ACC_W
  localparam logic [ACC_W-1:0] INC_MID =
    ACC_W'((64'(MID_KHZ) << ACC_W) / 64'(REF_KHZ));
  localparam logic [ACC_W-1:0] INC_LOW =
    ACC_W'((64'(LOW_KHZ) << ACC_W) / 64'(REF_KHZ));
  // each trim step moves the mid increment by one part in 256
  localparam int TRIM_SHIFT = 8;
  // mid rises counted before the pll model reports lock
  localparam int LOCK_RISES = 64;
endpackage : clksel_pkg

// [clk_switch_if.sv]
/*
  interface carrying one clock-switch request and its result between
  the top and the glitch-free switch. assumes one clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
interface clk_switch_if;
  logic [3:0] src_clk;
  logic [1:0] sel;
  logic       out_clk;
  logic [1:0] active;
  logic       busy;
  modport top (output src_clk, output sel,
               input out_clk, input active, input busy);
  modport sw  (input src_clk, input sel,
               output out_clk, output active, output busy);
endinterface : clk_switch_if
`default_nettype wire

// [glitchfree_mux.sv]
/*
  glitch-free selector among four modelled source clocks. the output
  is gated low, the old source released, then the new one enabled.
  assumes sources are slow waveforms sampled on the reference clock.
*/
`timescale 1ns/1ps
`default_nettype none
module glitchfree_mux (
  input  wire logic   clk_i,
  input  wire logic   rst_i,
  clk_switch_if.sw    sw
);
  typedef enum logic [1:0] {
    ST_RUN  = 2'b00,
    ST_WAITLOW = 2'b01,
    ST_SWAP = 2'b10
  } sw_state_t;
  sw_state_t  state_q;
  logic [1:0] act_q;
  logic       gate_q;
  logic       out_q;
  wire        cur_clk = sw.src_clk[act_q];
  wire        new_clk = sw.src_clk[sw.sel];
  wire        want    = (sw.sel != act_q);
  // gate only while the old clock is low, swap only while the new one is low, so no runt pulse
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= ST_RUN;
      act_q   <= 2'h0;
      gate_q  <= 1'b1;
    end else begin
      case (state_q)
        ST_RUN:     if (want && !cur_clk) begin
          gate_q  <= 1'b0;
          state_q <= ST_WAITLOW;
        end
        ST_WAITLOW: if (!new_clk) begin
          act_q   <= sw.sel;
          state_q <= ST_SWAP;
        end
        ST_SWAP: begin
          gate_q  <= 1'b1;
          state_q <= ST_RUN;
        end
        default:    state_q <= ST_RUN;
      endcase
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) out_q <= 1'b0;
    else       out_q <= gate_q & cur_clk;
  end
  assign sw.out_clk = out_q;
  assign sw.active  = act_q;
  assign sw.busy    = (state_q != ST_RUN) | want;
endmodule : glitchfree_mux
`default_nettype wire

// [clksel_props.sv]
/* assertions on the clock source select ports: pin use, source moves,
   system clock pulse widths. assumes it is bound to the top module. */
`timescale 1ns/1ps
`default_nettype none
module clksel_props (
  input wire logic       REF_CLK_I,
  input wire logic       RST_I,
  input wire logic [2:0] OSC_SELECT_CONFIG_I,
  input wire logic       CLOCK_OUT_ENABLE_I,
  input wire logic       RD_I,
  input wire logic [7:0] RDATA_O,
  input wire logic       CLOCK_OUT_PIN_O,
  input wire logic       CLOCK_OUT_PIN_OE_O,
  input wire logic       CLOCK_IN_GPIO_O,
  input wire logic       CLOCK_OUT_GPIO_O,
  input wire logic       SYS_CLK_O,
  input wire logic [1:0] SYS_SRC_O,
  input wire logic       SWITCH_BUSY_O
);
  logic [2:0] age_q;
  logic       up;
  logic       int_m;
  logic       pin_m;
  // strap is taken after reset, so mode checks wait a few cycles
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) age_q <= 3'h0;
    else if (!up) age_q <= age_q + 3'h1;
  end
  assign up    = age_q == 3'h7;
  assign int_m = up && OSC_SELECT_CONFIG_I == clksel_pkg::CFG_INT_MODE;
  assign pin_m = int_m ||
                 (up && OSC_SELECT_CONFIG_I == clksel_pkg::CFG_RC_MODE);
  default clocking @(posedge REF_CLK_I); endclocking
  default disable iff (RST_I);
  a_rdata_quiet: assert property (
    !$past(RD_I) |-> RDATA_O == 8'h00) else $error("stray read data");
  a_int_pin_free: assert property (
    int_m |-> CLOCK_IN_GPIO_O) else $error("input pin not released");
  a_out_pin_use: assert property (
    (pin_m && $stable(CLOCK_OUT_ENABLE_I))[*3] |->
    CLOCK_OUT_PIN_OE_O == CLOCK_OUT_ENABLE_I &&
    CLOCK_OUT_GPIO_O == !CLOCK_OUT_ENABLE_I) else $error("out pin use");
  a_pin_carries_clk: assert property (
    CLOCK_OUT_PIN_OE_O |-> CLOCK_OUT_PIN_O == SYS_CLK_O)
    else $error("out pin not system clock");
  a_rc_keeps_pin: assert property (
    SYS_SRC_O == clksel_pkg::SRC_RC |-> !CLOCK_IN_GPIO_O)
    else $error("rc pin released");
  a_int_not_rc: assert property (
    int_m |-> SYS_SRC_O != clksel_pkg::SRC_RC) else $error("rc in int");
  a_src_via_busy: assert property (
    up && $changed(SYS_SRC_O) |->
    $past(SWITCH_BUSY_O) || $past(SWITCH_BUSY_O, 2))
    else $error("source moved without switch");
  a_clk_high_min: assert property (
    $rose(SYS_CLK_O) |=> SYS_CLK_O[*2]) else $error("runt high");
  a_clk_low_min: assert property (
    $fell(SYS_CLK_O) |=> !SYS_CLK_O[*2]) else $error("runt low");
  c_switch: cover property ($rose(SWITCH_BUSY_O));
  c_high: cover property (SYS_SRC_O == clksel_pkg::SRC_HIGH);
  c_rc: cover property (SYS_SRC_O == clksel_pkg::SRC_RC);
endmodule : clksel_props
bind clock_source_select clksel_props u_props (
  .REF_CLK_I(REF_CLK_I), .RST_I(RST_I), .RD_I(RD_I), .RDATA_O(RDATA_O),
  .OSC_SELECT_CONFIG_I(OSC_SELECT_CONFIG_I),
  .CLOCK_OUT_ENABLE_I(CLOCK_OUT_ENABLE_I),
  .CLOCK_OUT_PIN_O(CLOCK_OUT_PIN_O),
  .CLOCK_OUT_PIN_OE_O(CLOCK_OUT_PIN_OE_O),
  .CLOCK_IN_GPIO_O(CLOCK_IN_GPIO_O), .CLOCK_OUT_GPIO_O(CLOCK_OUT_GPIO_O),
  .SYS_CLK_O(SYS_CLK_O), .SYS_SRC_O(SYS_SRC_O),
  .SWITCH_BUSY_O(SWITCH_BUSY_O));
`default_nettype wire

// [tb_top.sv]
/* self-checking bench for clock_source_select: register port, source
   switching, clock rates, pin use. assumes design files compile first. */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  typedef struct packed {logic [7:0] ctl; logic [1:0] src;} row_t;
  // last row: the unused internal choice falls back to the low source
  row_t rows [6] = '{'{8'h02, 2'h0}, '{8'h06, 2'h1}, '{8'h0a, 2'h2},
                     '{8'h07, 2'h1}, '{8'h0b, 2'h2}, '{8'h0e, 2'h0}};
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic [2:0] cfg = clksel_pkg::CFG_INT_MODE;
  logic       en = 1'b1;
  logic [1:0] addr = 2'h0;
  logic [7:0] wdata = 8'h00;
  logic       wr = 1'b0;
  logic       rd = 1'b0;
  logic       pin = 1'b0;
  logic [7:0] rdata, d;
  logic       o_pin, o_oe, i_gpio, o_gpio, sclk, busy, lock;
  logic [1:0] src;
  int         fails = 0, n_compared = 0, cycles = 0, rises = 0, n0, n1;
  clock_source_select dut (.REF_CLK_I(clk), .RST_I(rst),
    .OSC_SELECT_CONFIG_I(cfg), .CLOCK_OUT_ENABLE_I(en), .ADDR_I(addr),
    .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata),
    .CLOCK_IN_PIN_I(pin), .CLOCK_OUT_PIN_O(o_pin),
    .CLOCK_OUT_PIN_OE_O(o_oe), .CLOCK_IN_GPIO_O(i_gpio),
    .CLOCK_OUT_GPIO_O(o_gpio), .SYS_CLK_O(sclk), .SYS_SRC_O(src),
    .SWITCH_BUSY_O(busy), .HIGH_FREQ_LOCK_O(lock));
  always #20 clk = ~clk;
  always @(posedge sclk) rises++;
  // rc network on the input pin: slow square wave, 20 cycles a period
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles % 10 == 0) pin <= ~pin;
    if (cycles == 60000) begin
      fails++;
      end_of_test();
    end
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wreg(input logic [1:0] a, input logic [7:0] v);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    // one idle edge, so a following write never re-drives wr at once
    @(posedge clk);
  endtask : wreg
  // read data stand only in the cycle after the strobe
  task automatic rreg(input logic [1:0] a, output logic [7:0] v);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
    @(posedge clk);
  endtask : rreg
  task automatic settle();
    repeat (3) @(posedge clk);
    for (int k = 0; k < 8000 && busy !== 1'b0; k++) @(posedge clk);
  endtask : settle
  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : end_of_test
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    settle();
    check(8'(src), 8'h00);
    check(8'(i_gpio), 8'h01);
    rreg(clksel_pkg::ADDR_CONTROL, d);
    check(d, clksel_pkg::CONTROL_RESET);
    foreach (rows[i]) begin
      wreg(clksel_pkg::ADDR_CONTROL, rows[i].ctl);
      settle();
      check(8'(src), 8'(rows[i].src));
      rreg(clksel_pkg::ADDR_CONTROL, d);
      check(d, rows[i].ctl);
      rreg(clksel_pkg::ADDR_STATUS, d);
      check(d & 8'h0f, 8'({5'h01, rows[i].src}));
    end
    // mid source: 500 kHz against 25 MHz is 20 rises in 1000 cycles
    wreg(clksel_pkg::ADDR_CONTROL, 8'h06);
    settle();
    n0 = rises;
    repeat (1000) @(posedge clk);
    n0 = rises - n0;
    check(8'(n0 >= 19 && n0 <= 21), 8'h01);
    wreg(clksel_pkg::ADDR_TRIM, 8'h1f);
    repeat (100) @(posedge clk);
    n1 = rises;
    repeat (1000) @(posedge clk);
    n1 = rises - n1;
    check(8'(n1 > n0), 8'h01);
    rreg(clksel_pkg::ADDR_TRIM, d);
    check(d, 8'h1f);
    wreg(clksel_pkg::ADDR_TRIM, 8'hff);
    wreg(2'h3, 8'h5a);
    rreg(2'h3, d);
    check(d, 8'h00);
    rreg(clksel_pkg::ADDR_TRIM, d);
    check(d, 8'h3f);
    en <= 1'b0;
    repeat (4) @(posedge clk);
    check(8'({o_oe, o_gpio, i_gpio}), 8'h03);
    // reset lands in mid switch, then the strap asks for the rc network
    wreg(clksel_pkg::ADDR_CONTROL, 8'h0a);
    rst <= 1'b1;
    cfg <= clksel_pkg::CFG_RC_MODE;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    settle();
    check(8'(src), 8'(clksel_pkg::SRC_RC));
    check(8'(lock), 8'h00);
    check(8'({o_oe, o_gpio, i_gpio}), 8'h02);
    en <= 1'b1;
    repeat (4) @(posedge clk);
    check(8'({o_oe, o_gpio, i_gpio}), 8'h04);
    // software leaves the rc network: pin held until the move is done
    wreg(clksel_pkg::ADDR_CONTROL, 8'h06);
    check(8'(i_gpio), 8'h00);
    settle();
    check(8'(src), 8'(clksel_pkg::SRC_MID));
    check(8'({o_oe, o_gpio, i_gpio}), 8'h05);
    repeat (clksel_pkg::LOCK_RISES *
            (clksel_pkg::REF_KHZ / clksel_pkg::MID_KHZ)) @(posedge clk);
    check(8'(lock), 8'h01);
    check(8'(o_pin), 8'(sclk));
    // high marker toggles once per mid rise: 10 rises in 1000 cycles
    wreg(clksel_pkg::ADDR_CONTROL, 8'h0a);
    settle();
    n0 = rises;
    repeat (1000) @(posedge clk);
    n0 = rises - n0;
    check(8'(n0 >= 9 && n0 <= 11), 8'h01);
    end_of_test();
  end
endmodule : tb_top
`default_nettype wire
